//--- logic/clock_config_cfg.svh
`ifndef CLOCK_CONFIG_CFG_SVH
`define CLOCK_CONFIG_CFG_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define ADDR_PRODUCT_INFO      4'h0
`define ADDR_MEM_CLK_CFG       4'h4
`define ADDR_PIX_CLK_CFG       4'h8

// ************************************************************
// product information fields
// ************************************************************
`define PI_PRODUCT_HI_LSB      26
`define PI_REVISION_HI_LSB     24
`define PI_STRAP_LSB           16
`define PI_BUFFER_LSB          8
`define PI_PRODUCT_LO_LSB      2
`define PI_REVISION_LO_LSB     0
`define STRAP_RESERVED_IDX     3
// arbitrary identity values
`define PRODUCT_CODE           6'h15
`define REVISION_CODE          2'h1
// buffer size in 4k byte units
`define BUFFER_SIZE_4K         8'h28

// ************************************************************
// clock configuration fields and reset values
// ************************************************************
`define MEM_DIV_LSB            4
`define PIX_DIV_LSB            4
`define PIX_SRC_LSB            0
`define MEM_DIV_RESET          2'h0
`define PIX_DIV_RESET          3'h0
`define PIX_SRC_RESET          2'h0
`define PIX_DIV_BY8            3'h4
`define DIV_COUNT_BY8          4'h7
`define PIX_SRC_MEM            2'h0
`define PIX_SRC_BUS            2'h1
`define PIX_SRC_PRIMARY        2'h2
`define PIX_SRC_SECONDARY      2'h3

// ************************************************************
// timing counts
// ************************************************************
// cycles after reset release before the strap pipeline is full
`define STRAP_SETTLE_CYCLES    2'h3

`endif

//--- logic/clock_config_pkg.sv
package clock_config_pkg;

  typedef logic [6:0] strap_type;
  typedef logic [3:0] div_count_type;
  typedef logic [1:0] pix_source_type;

  typedef enum logic [0:0] {
    bus_idle,
    bus_answer
  } bus_state_type;

  typedef enum logic [0:0] {
    strap_fill,
    strap_held
  } strap_state_type;

endpackage

//--- logic/clock_tick_if.sv
`timescale 1ns/1ps

interface clock_tick_if;
  logic tick;

  modport source (output tick);
  modport sink   (input  tick);
endinterface

//--- logic/pin_edge_sync.sv
`timescale 1ns/1ps

// ************************************************************
// external clock pin to one-cycle rising edge tick
// ************************************************************
module pin_edge_sync (
  input  wire logic            core_clk_i,
  input  wire logic            resetn_i,
  input  wire logic            pin_i,
  clock_tick_if.source         tick_out
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;
  logic edge_tick;
  logic next_level;
  logic next_edge_tick;

  // a change only counts once the last two stages agree
  always_comb begin
    next_level     = level;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
    next_edge_tick = next_level & ~level;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1    <= 1'b0;
      stage2    <= 1'b0;
      stage3    <= 1'b0;
      level     <= 1'b0;
      edge_tick <= 1'b0;
    end else begin
      stage1    <= pin_i;
      stage2    <= stage1;
      stage3    <= stage2;
      level     <= next_level;
      edge_tick <= next_edge_tick;
    end
  end

  assign tick_out.tick = edge_tick;

endmodule

//--- logic/tick_divider.sv
`timescale 1ns/1ps

// ************************************************************
// divides a tick stream by terminal count plus one
// ************************************************************
module tick_divider (
  input  wire logic                          core_clk_i,
  input  wire logic                          resetn_i,
  input  wire clock_config_pkg::div_count_type terminal_i,
  clock_tick_if.sink                         tick_in,
  clock_tick_if.source                       tick_out
);

  clock_config_pkg::div_count_type count;
  clock_config_pkg::div_count_type next_count;
  logic                            out_tick;
  logic                            next_out_tick;

  // >= so that lowering the ratio mid-count cannot overrun
  always_comb begin
    next_count    = count;
    next_out_tick = 1'b0;
    if (tick_in.tick) begin
      if (count >= terminal_i) begin
        next_count    = 4'h0;
        next_out_tick = 1'b1;
      end else begin
        next_count = count + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count    <= 4'h0;
      out_tick <= 1'b0;
    end else begin
      count    <= next_count;
      out_tick <= next_out_tick;
    end
  end

  assign tick_out.tick = out_tick;

endmodule

//--- logic/clock_config_and_product_info.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "clock_config_cfg.svh"

module clock_config_and_product_info (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [6:0]  config_strap_pins_i,
  input  wire logic        primary_clock_input_i,
  input  wire logic        secondary_clock_input_i,
  output logic             mem_clk_tick_o,
  output logic             pix_clk_tick_o
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic clock_config_pkg::div_count_type pix_terminal(input logic [2:0] code);
    clock_config_pkg::div_count_type t;
    t = {1'b0, code};
    // reserved codes fall back to the slowest ratio
    if (code >= `PIX_DIV_BY8) begin
      t = `DIV_COUNT_BY8;
    end
    return t;
  endfunction

  // one decode shared by the write path and the read mux
  function automatic logic [2:0] reg_hit(input logic [3:0] addr);
    logic [2:0] hit;
    hit = 3'h0;
    if (addr == `ADDR_PRODUCT_INFO) begin
      hit[0] = 1'b1;
    end else if (addr == `ADDR_MEM_CLK_CFG) begin
      hit[1] = 1'b1;
    end else if (addr == `ADDR_PIX_CLK_CFG) begin
      hit[2] = 1'b1;
    end
    return hit;
  endfunction

  // ************************************************************
  // strap capture
  // ************************************************************
  clock_config_pkg::strap_type       strap_s1;
  clock_config_pkg::strap_type       strap_s2;
  clock_config_pkg::strap_type       strap_s3;
  clock_config_pkg::strap_type       strap_latched;
  clock_config_pkg::strap_type       next_strap_latched;
  clock_config_pkg::strap_state_type strap_state;
  clock_config_pkg::strap_state_type next_strap_state;
  logic [1:0]                        settle;
  logic [1:0]                        next_settle;

  // straps cannot be taken under async reset, so they are
  // sampled once the pipeline behind the release is full
  always_comb begin
    next_strap_latched = strap_latched;
    next_strap_state   = strap_state;
    next_settle        = settle;
    case (strap_state)
      clock_config_pkg::strap_fill: begin
        if (settle != `STRAP_SETTLE_CYCLES) begin
          next_settle = settle + 2'h1;
        end else if (strap_s2 == strap_s3) begin
          next_strap_latched = strap_s3;
          next_strap_state   = clock_config_pkg::strap_held;
        end
      end
      clock_config_pkg::strap_held: begin
        next_strap_state = clock_config_pkg::strap_held;
      end
      default: begin
        next_strap_state = clock_config_pkg::strap_fill;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_s1      <= 7'h00;
      strap_s2      <= 7'h00;
      strap_s3      <= 7'h00;
      strap_latched <= 7'h00;
      strap_state   <= clock_config_pkg::strap_fill;
      settle        <= 2'h0;
    end else begin
      strap_s1      <= config_strap_pins_i;
      strap_s2      <= strap_s1;
      strap_s3      <= strap_s2;
      strap_latched <= next_strap_latched;
      strap_state   <= next_strap_state;
      settle        <= next_settle;
    end
  end

  // ************************************************************
  // product information word
  // ************************************************************
  logic [31:0]                 product_info;
  clock_config_pkg::strap_type strap_view;

  always_comb begin
    strap_view                        = strap_latched;
    strap_view[`STRAP_RESERVED_IDX]   = 1'b1;
    product_info                      = 32'h0000_0000;
    product_info[`PI_PRODUCT_HI_LSB +: 6]  = `PRODUCT_CODE;
    product_info[`PI_REVISION_HI_LSB +: 2] = `REVISION_CODE;
    product_info[`PI_STRAP_LSB +: 7]       = strap_view;
    product_info[`PI_BUFFER_LSB +: 8]      = `BUFFER_SIZE_4K;
    product_info[`PI_PRODUCT_LO_LSB +: 6]  = `PRODUCT_CODE;
    product_info[`PI_REVISION_LO_LSB +: 2] = `REVISION_CODE;
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [1:0] mem_div;
  logic [2:0] pix_div;
  logic [1:0] pix_src;
  logic [1:0] next_mem_div;
  logic [2:0] next_pix_div;
  logic [1:0] next_pix_src;
  logic       write_commit;
  logic [2:0] reg_sel;

  assign reg_sel = reg_hit(avs_address_i);

  always_comb begin
    next_mem_div = mem_div;
    next_pix_div = pix_div;
    next_pix_src = pix_src;
    // all writable fields live in byte lane 0
    if (write_commit && avs_byteenable_i[0]) begin
      if (reg_sel[0]) begin
        next_mem_div = mem_div;
      end else if (reg_sel[1]) begin
        // bit 0 is not stored; software keeps it zero
        next_mem_div = avs_writedata_i[`MEM_DIV_LSB +: 2];
      end else if (reg_sel[2]) begin
        next_pix_div = avs_writedata_i[`PIX_DIV_LSB +: 3];
        next_pix_src = avs_writedata_i[`PIX_SRC_LSB +: 2];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_div <= `MEM_DIV_RESET;
      pix_div <= `PIX_DIV_RESET;
      pix_src <= `PIX_SRC_RESET;
    end else begin
      mem_div <= next_mem_div;
      pix_div <= next_pix_div;
      pix_src <= next_pix_src;
    end
  end

  // ************************************************************
  // avalon-mm slave
  // ************************************************************
  clock_config_pkg::bus_state_type bus_state;
  clock_config_pkg::bus_state_type next_bus_state;
  logic                            next_waitrequest;
  logic [31:0]                     next_readdata;
  logic [31:0]                     read_word;

  always_comb begin
    read_word = 32'h0000_0000;
    if (reg_sel[0]) begin
      read_word = product_info;
    end else if (reg_sel[1]) begin
      read_word[`MEM_DIV_LSB +: 2] = mem_div;
    end else if (reg_sel[2]) begin
      read_word[`PIX_DIV_LSB +: 3] = pix_div;
      read_word[`PIX_SRC_LSB +: 2] = pix_src;
    end
  end

  // requests wait until the straps are held, so the first read
  // of product information can never show unsettled pins
  always_comb begin
    next_bus_state   = bus_state;
    next_waitrequest = avs_waitrequest_o;
    next_readdata    = avs_readdata_o;
    write_commit     = 1'b0;
    case (bus_state)
      clock_config_pkg::bus_idle: begin
        if ((strap_state == clock_config_pkg::strap_held) && (avs_read_i || avs_write_i)) begin
          next_bus_state   = clock_config_pkg::bus_answer;
          next_waitrequest = 1'b0;
          next_readdata    = avs_read_i ? read_word : 32'h0000_0000;
        end
      end
      clock_config_pkg::bus_answer: begin
        // writes land only at the edge the master sees the answer
        write_commit     = avs_write_i;
        next_bus_state   = clock_config_pkg::bus_idle;
        next_waitrequest = 1'b1;
      end
      default: begin
        next_bus_state   = clock_config_pkg::bus_idle;
        next_waitrequest = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_state         <= clock_config_pkg::bus_idle;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      bus_state         <= next_bus_state;
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o    <= next_readdata;
    end
  end

  // ************************************************************
  // clock derivation
  // ************************************************************
  clock_tick_if bus_tick ();
  clock_tick_if mem_tick ();
  clock_tick_if primary_tick ();
  clock_tick_if secondary_tick ();
  clock_tick_if pix_source_tick ();
  clock_tick_if pix_tick ();

  assign bus_tick.tick = 1'b1;

  tick_divider mem_divider (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .terminal_i ({2'b00, mem_div}),
    .tick_in    (bus_tick),
    .tick_out   (mem_tick)
  );

  // external clocks must stay well below a quarter of the bus clock
  pin_edge_sync primary_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .pin_i      (primary_clock_input_i),
    .tick_out   (primary_tick)
  );

  pin_edge_sync secondary_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .pin_i      (secondary_clock_input_i),
    .tick_out   (secondary_tick)
  );

  always_comb begin
    case (pix_src)
      `PIX_SRC_MEM:     pix_source_tick.tick = mem_tick.tick;
      `PIX_SRC_BUS:     pix_source_tick.tick = bus_tick.tick;
      `PIX_SRC_PRIMARY: pix_source_tick.tick = primary_tick.tick;
      default:          pix_source_tick.tick = secondary_tick.tick;
    endcase
  end

  tick_divider pix_divider (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .terminal_i (pix_terminal(pix_div)),
    .tick_in    (pix_source_tick),
    .tick_out   (pix_tick)
  );

  logic next_mem_out;
  logic next_pix_out;

  always_comb begin
    next_mem_out = mem_tick.tick;
    next_pix_out = pix_tick.tick;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_clk_tick_o <= 1'b0;
      pix_clk_tick_o <= 1'b0;
    end else begin
      mem_clk_tick_o <= next_mem_out;
      pix_clk_tick_o <= next_pix_out;
    end
  end

endmodule

//--- verification/clock_config_and_product_info_assertions.sv
`timescale 1ns/1ps
`include "clock_config_cfg.svh"

// ************************************************************
// bus answer, read fields and tick spacing
// ************************************************************
module clock_config_and_product_info_assertions (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        mem_clk_tick_o,
  input wire logic        pix_clk_tick_o
);
  logic [1:0] mcode;
  logic [2:0] pdiv;
  logic [1:0] psrc;
  logic [3:0] quiet;
  logic [3:0] mhist;
  logic [7:0] phist;
  logic [6:0] last_strap;
  logic       have_strap;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // shadow of the configuration; quiet counts cycles since any write request
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mcode      <= 2'h0;
      pdiv       <= 3'h0;
      psrc       <= 2'h0;
      quiet      <= 4'h0;
      have_strap <= 1'b0;
      last_strap <= 7'h00;
    end else begin
      quiet <= avs_write_i ? 4'h0 : (quiet == 4'hf ? quiet : quiet + 4'h1);
      if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]) begin
        if (avs_address_i == `ADDR_MEM_CLK_CFG) mcode <= avs_writedata_i[5:4];
        if (avs_address_i == `ADDR_PIX_CLK_CFG) pdiv <= avs_writedata_i[6:4];
        if (avs_address_i == `ADDR_PIX_CLK_CFG) psrc <= avs_writedata_i[1:0];
      end
      if (avs_read_i && !avs_waitrequest_o && avs_address_i == `ADDR_PRODUCT_INFO) begin
        have_strap <= 1'b1;
        last_strap <= avs_readdata_o[22:16];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    mhist <= {mhist[2:0], mem_clk_tick_o};
    phist <= {phist[6:0], pix_clk_tick_o};
  end

  sequence s_info_read;
    avs_read_i && !avs_waitrequest_o && avs_address_i == `ADDR_PRODUCT_INFO;
  endsequence

  sequence s_pending;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  a_wait_single:   assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
  a_answer_bound:  assert property (s_pending |-> ##[1:12] !avs_waitrequest_o) else $error("no bus answer");
  a_product_ids:   assert property (s_info_read |-> avs_readdata_o[31:26] == `PRODUCT_CODE &&
    avs_readdata_o[7:2] == `PRODUCT_CODE && avs_readdata_o[25:24] == `REVISION_CODE &&
    avs_readdata_o[1:0] == `REVISION_CODE) else $error("identity field wrong");
  a_buffer_size:   assert property (s_info_read |-> avs_readdata_o[15:8] == 8'h28)
    else $error("buffer size wrong");
  a_strap_three:   assert property (s_info_read |-> avs_readdata_o[19]) else $error("strap three not one");
  a_strap_latched: assert property (s_info_read |-> !have_strap || avs_readdata_o[22:16] == last_strap)
    else $error("strap status changed");
  a_mem_full:      assert property (quiet == 4'hf && mcode == 2'h0 |-> mem_clk_tick_o)
    else $error("memory tick missing at ratio one");
  a_mem_quarter:   assert property (quiet == 4'hf && mcode == 2'h3 && mem_clk_tick_o |-> mhist == 4'h8)
    else $error("memory tick spacing wrong");
  a_pix_bus_full:  assert property (quiet == 4'hf && psrc == 2'h1 && pdiv == 3'h0 |-> pix_clk_tick_o)
    else $error("pixel tick missing from bus source");
  a_pix_eighth:    assert property (quiet == 4'hf && psrc == 2'h1 && pdiv == 3'h4 && pix_clk_tick_o |->
    phist == 8'h80) else $error("pixel divide by eight wrong");
endmodule

//--- verification/clock_config_and_product_info_tb.sv
`timescale 1ns/1ps
`include "clock_config_cfg.svh"

module clock_config_and_product_info_tb;
  logic        core_clk_i              = 1'b0;
  logic        resetn_i                = 1'b0;
  logic [3:0]  avs_address_i           = 4'h0;
  logic        avs_read_i              = 1'b0;
  logic        avs_write_i             = 1'b0;
  logic [31:0] avs_writedata_i         = 32'h0;
  logic [3:0]  avs_byteenable_i        = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [6:0]  config_strap_pins_i     = 7'h52;
  logic        primary_clock_input_i   = 1'b0;
  logic        secondary_clock_input_i = 1'b0;
  logic        mem_clk_tick_o;
  logic        pix_clk_tick_o;
  logic [2:0]  ext_cnt                 = 3'h0;
  logic [3:0]  sec_cnt                 = 4'h0;
  int          mismatches              = 0;
  int          num_checks              = 0;

  always #50 core_clk_i = ~core_clk_i;

  // external clocks: periods of 8 and 12 bus cycles
  always @(posedge core_clk_i) begin
    ext_cnt <= ext_cnt + 3'h1;
    sec_cnt <= (sec_cnt == 4'hb) ? 4'h0 : sec_cnt + 4'h1;
    primary_clock_input_i <= ext_cnt[2];
    secondary_clock_input_i <= (sec_cnt < 4'h6);
  end

  clock_config_and_product_info dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .config_strap_pins_i(config_strap_pins_i), .primary_clock_input_i(primary_clock_input_i),
    .secondary_clock_input_i(secondary_clock_input_i), .mem_clk_tick_o(mem_clk_tick_o),
    .pix_clk_tick_o(pix_clk_tick_o));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_read_i <= !w;
    avs_write_i <= w;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n == 50) begin
      mismatches++;
      $display("mismatch at %0t: bus timeout", $time);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask

  // settle after a write, then count ticks over a window
  task automatic count(input int cyc, output int mc, output int pc);
    mc = 0;
    pc = 0;
    repeat (16) @(posedge core_clk_i);
    repeat (cyc) begin
      @(posedge core_clk_i);
      mc += (mem_clk_tick_o === 1'b1);
      pc += (pix_clk_tick_o === 1'b1);
    end
  endtask

  function automatic logic [31:0] info(input logic [6:0] s);
    return {`PRODUCT_CODE, `REVISION_CODE, 1'b0, s, 8'h28, `PRODUCT_CODE, `REVISION_CODE};
  endfunction

  task automatic do_reset(input logic [6:0] s);
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    config_strap_pins_i <= s;
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b1;
  endtask

  task automatic identity(input logic [6:0] exp_s);
    rd(`ADDR_PRODUCT_INFO, info(exp_s));
    config_strap_pins_i <= ~config_strap_pins_i;
    rd(`ADDR_PRODUCT_INFO, info(exp_s));
    wr(`ADDR_PRODUCT_INFO, 32'hffffffff);
    rd(`ADDR_PRODUCT_INFO, info(exp_s));
    rd(4'hc, 32'h0);
  endtask

  task automatic reset_values;
    rd(`ADDR_MEM_CLK_CFG, 32'h0);
    rd(`ADDR_PIX_CLK_CFG, 32'h0);
  endtask

  task automatic mem_divide;
    int mc, pc;
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_MEM_CLK_CFG, {26'h0, c[1:0], 4'h0});
      rd(`ADDR_MEM_CLK_CFG, {26'h0, c[1:0], 4'h0});
      count(24, mc, pc);
      chk(mc, 24 / (c + 1));
      chk(pc, mc);
    end
  endtask

  task automatic pix_divide;
    int ratio [5] = '{1, 2, 3, 4, 8};
    int mc, pc;
    logic [31:0] q;
    wr(`ADDR_MEM_CLK_CFG, 32'h10);
    for (int c = 0; c < 5; c++) begin
      wr(`ADDR_PIX_CLK_CFG, {25'h0, c[2:0], 4'h1});
      rd(`ADDR_PIX_CLK_CFG, {25'h0, c[2:0], 4'h1});
      count(48, mc, pc);
      chk(pc, 48 / ratio[c]);
    end
    bus(1'b1, `ADDR_PIX_CLK_CFG, 32'h0, 4'he, q);
    rd(`ADDR_PIX_CLK_CFG, 32'h41);
    wr(`ADDR_PIX_CLK_CFG, 32'h10);
    count(48, mc, pc);
    chk(pc, 12);
  endtask

  task automatic external;
    int mc, pc;
    wr(`ADDR_PIX_CLK_CFG, 32'h2);
    count(96, mc, pc);
    chk(pc, 12);
    wr(`ADDR_PIX_CLK_CFG, 32'h3);
    count(96, mc, pc);
    chk(pc, 8);
  endtask

  initial begin
    do_reset(7'h52);
    identity(7'h5a);
    reset_values();
    mem_divide();
    pix_divide();
    external();
    do_reset(7'h25);
    reset_values();
    identity(7'h2d);
    tally_and_finish();
  end
endmodule

bind clock_config_and_product_info clock_config_and_product_info_assertions u_chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .mem_clk_tick_o(mem_clk_tick_o), .pix_clk_tick_o(pix_clk_tick_o));
